// File: sar_adc_conversion_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctrl_params.svh"
module sar_adc_conversion_control #(
   parameter int W  = `RES_BITS,
   parameter int NC = `NUM_CH,
   parameter int SD = `SEQ_DEPTH
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         convert_start,
   input  wire logic         comp_in,
   input  wire logic [2:0]   chan_sel,
   input  wire logic [2:0]   span_sel,
   input  wire logic         seq_enable,
   input  wire logic         seq_write,
   input  wire logic [2:0]   seq_addr,
   input  wire logic [5:0]   seq_data,
   input  wire logic [2:0]   seq_len_m1,
   input  wire logic         lvds_select,
   input  wire logic         nap_req,
   input  wire logic         pd_req,
   output logic              busy,
   output logic              hold,
   output logic [NC-1:0]     mux_en,
   output logic [W-1:0]      dac_code,
   output logic [W-1:0]      out_data,
   output logic [2:0]        out_chan,
   output logic [2:0]        out_span,
   output logic              out_valid,
   output logic              cmos_en,
   output logic              lvds_en,
   output logic              nap,
   output logic              power_down
);
   // ****************************************
   // Checks
   // ****************************************
   // Pointer and list address are three bits wide
   if (W != 18 || NC != 8 || SD > 8 || SD < 1) begin : g_bad_params
      $error("unsupported parameters");
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] cs_sync_reg;
   logic [1:0] lv_sync_reg, nap_sync_reg, pd_sync_reg;
   always_ff @(posedge mclk) begin
      if (reset) begin
         cs_sync_reg  <= 3'h0;
         lv_sync_reg  <= 2'h0;
         nap_sync_reg <= 2'h0;
         pd_sync_reg  <= 2'h0;
      end else begin
         cs_sync_reg  <= {cs_sync_reg[1:0], convert_start};
         lv_sync_reg  <= {lv_sync_reg[0], lvds_select};
         nap_sync_reg <= {nap_sync_reg[0], nap_req};
         pd_sync_reg  <= {pd_sync_reg[0], pd_req};
      end
   end
   // Edge taken on the second and third stages only
   logic cs_rise;
   assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];

   // ****************************************
   // Sequencer memory
   // ****************************************
   logic [5:0] seq_mem [SD];
   logic [2:0] seq_ptr_reg, seq_ptr_next;
   always_ff @(posedge mclk) begin
      if (seq_write) seq_mem[seq_addr] <= seq_data;
   end

   // ****************************************
   // Conversion control
   // ****************************************
   sar_ctrl_pkg::conv_state_t st_reg, st_next;
   logic         busy_reg, busy_next, hold_reg, hold_next, valid_reg, valid_next;
   logic [NC-1:0] mux_reg, mux_next;
   logic [2:0]   ch_reg, ch_next, sp_reg, sp_next, och_reg, och_next, osp_reg, osp_next;
   logic [W-1:0] data_reg, data_next;
   logic         search_start, search_done;
   logic [W-1:0] search_result, search_dac;
   logic [2:0]   pick_ch, pick_sp;
   logic         bipolar;

   always_comb begin
      if (seq_enable) begin
         pick_ch = seq_mem[seq_ptr_reg][5:3];
         pick_sp = seq_mem[seq_ptr_reg][2:0];
      end else begin
         pick_ch = chan_sel;
         pick_sp = span_sel;
      end
   end
   logic [7:0] bip_mask;
   assign bip_mask = `SPAN_BIPOLAR_MASK;
   assign bipolar  = bip_mask[sp_reg];

   always_comb begin
      st_next      = st_reg;
      busy_next    = busy_reg;
      hold_next    = hold_reg;
      valid_next   = 1'b0;
      mux_next     = mux_reg;
      ch_next      = ch_reg;
      sp_next      = sp_reg;
      och_next     = och_reg;
      osp_next     = osp_reg;
      data_next    = data_reg;
      seq_ptr_next = seq_ptr_reg;
      search_start = 1'b0;
      unique case (st_reg)
         sar_ctrl_pkg::ST_ACQ: begin
            // All channels track, so a new mux choice needs no wait
            if (cs_rise && !power_down && !nap) begin
               st_next      = sar_ctrl_pkg::ST_CONV;
               busy_next    = 1'b1;
               hold_next    = 1'b1;
               ch_next      = pick_ch;
               sp_next      = pick_sp;
               mux_next     = NC'(1) << pick_ch;
               search_start = 1'b1;
               if (seq_enable)
                  seq_ptr_next = (seq_ptr_reg >= seq_len_m1) ? 3'h0 : seq_ptr_reg + 3'h1;
            end
            if (!seq_enable) seq_ptr_next = 3'h0;
         end
         sar_ctrl_pkg::ST_CONV: begin
            if (search_done) begin
               st_next = sar_ctrl_pkg::ST_DONE;
               // Flip the MSB to turn offset binary into two's complement
               data_next = bipolar ? (search_result ^ {1'b1, {(W-1){1'b0}}})
                                   : search_result;
               och_next  = ch_reg;
               osp_next  = sp_reg;
            end
         end
         sar_ctrl_pkg::ST_DONE: begin
            st_next    = sar_ctrl_pkg::ST_ACQ;
            valid_next = 1'b1;
            busy_next  = 1'b0;
            hold_next  = 1'b0;
            mux_next   = '0;
         end
         default: begin
            st_next = sar_ctrl_pkg::ST_ACQ;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg      <= sar_ctrl_pkg::ST_ACQ;
         busy_reg    <= 1'b0;
         hold_reg    <= 1'b0;
         valid_reg   <= 1'b0;
         mux_reg     <= '0;
         ch_reg      <= 3'h0;
         sp_reg      <= 3'h0;
         och_reg     <= 3'h0;
         osp_reg     <= 3'h0;
         data_reg    <= '0;
         seq_ptr_reg <= 3'h0;
      end else begin
         st_reg      <= st_next;
         busy_reg    <= busy_next;
         hold_reg    <= hold_next;
         valid_reg   <= valid_next;
         mux_reg     <= mux_next;
         ch_reg      <= ch_next;
         sp_reg      <= sp_next;
         och_reg     <= och_next;
         osp_reg     <= osp_next;
         data_reg    <= data_next;
         seq_ptr_reg <= seq_ptr_next;
      end
   end

   sar_search #(.W(W)) u_search (
      .mclk     (mclk),
      .reset    (reset),
      .start    (search_start),
      .comp_in  (comp_in),
      .dac_code (search_dac),
      .result   (search_result),
      .done     (search_done)
   );

   // ****************************************
   // Port select and power states
   // ****************************************
   logic cmos_reg, lvds_reg, nap_reg, pd_reg;
   logic cmos_next, lvds_next, nap_next, pd_next;
   logic idle;
   // Judged on the next state, so a start and a nap never land together
   assign idle = (st_next == sar_ctrl_pkg::ST_ACQ) && !busy_next;
   always_comb begin
      cmos_next = ~lv_sync_reg[1];
      lvds_next = lv_sync_reg[1];
      // Power states only entered while idle
      nap_next  = idle ? nap_sync_reg[1] : nap_reg;
      pd_next   = idle ? pd_sync_reg[1] : pd_reg;
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmos_reg <= 1'b1;
         lvds_reg <= 1'b0;
         nap_reg  <= 1'b0;
         pd_reg   <= 1'b0;
      end else begin
         cmos_reg <= cmos_next;
         lvds_reg <= lvds_next;
         nap_reg  <= nap_next;
         pd_reg   <= pd_next;
      end
   end

   assign busy       = busy_reg;
   assign hold       = hold_reg;
   assign mux_en     = mux_reg;
   // Comparator must judge the trial of this very cycle, so no extra stage
   assign dac_code   = search_dac;
   assign out_data   = data_reg;
   assign out_chan   = och_reg;
   assign out_span   = osp_reg;
   assign out_valid  = valid_reg;
   assign cmos_en    = cmos_reg;
   assign lvds_en    = lvds_reg;
   assign nap        = nap_reg;
   assign power_down = pd_reg;

   // ****************************************
   // Assertions
   // ****************************************
   property p_start_busy;
      @(posedge mclk) disable iff (reset)
      (st_reg == sar_ctrl_pkg::ST_ACQ && cs_rise && !nap && !power_down) |=> busy && hold;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("no busy after start");
   property p_conv_len;
      @(posedge mclk) disable iff (reset)
      $rose(busy) |-> ##20 out_valid;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("result timing wrong");
   property p_busy_ends;
      @(posedge mclk) disable iff (reset) out_valid |-> !busy && mux_en == '0;
   endproperty
   a_busy_ends: assert property (p_busy_ends) else $error("busy after result");
   property p_onemux;
      @(posedge mclk) disable iff (reset) busy |-> $onehot(mux_en);
   endproperty
   a_onemux: assert property (p_onemux) else $error("mux not one channel");
   property p_bip;
      @(posedge mclk) disable iff (reset)
      (st_reg == sar_ctrl_pkg::ST_CONV && search_done && bipolar)
      |=> out_data[W-1] != $past(search_result[W-1]);
   endproperty
   a_bip: assert property (p_bip) else $error("bipolar format wrong");
   property p_uni;
      @(posedge mclk) disable iff (reset)
      (st_reg == sar_ctrl_pkg::ST_CONV && search_done && !bipolar)
      |=> out_data == $past(search_result);
   endproperty
   a_uni: assert property (p_uni) else $error("unipolar format wrong");
   property p_port;
      @(posedge mclk) disable iff (reset) cmos_en != lvds_en;
   endproperty
   a_port: assert property (p_port) else $error("port select broken");
   property p_chan;
      @(posedge mclk) disable iff (reset)
      (st_reg == sar_ctrl_pkg::ST_ACQ && cs_rise && !nap && !power_down && !seq_enable)
      |=> ch_reg == $past(chan_sel) && sp_reg == $past(span_sel);
   endproperty
   a_chan: assert property (p_chan) else $error("selection not applied");
   property p_nap_idle;
      @(posedge mclk) disable iff (reset) $rose(nap) |-> !busy;
   endproperty
   a_nap_idle: assert property (p_nap_idle) else $error("nap while busy");
   property p_first_trial;
      @(posedge mclk) disable iff (reset)
      $rose(busy) |-> dac_code == {1'b1, {(W-1){1'b0}}};
   endproperty
   a_first_trial: assert property (p_first_trial) else $error("search not from half");
   property p_valid_pulse;
      @(posedge mclk) disable iff (reset) out_valid |=> !out_valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("result strobe too long");
   property p_idle_mux;
      @(posedge mclk) disable iff (reset) !busy |-> mux_en == '0 && !hold;
   endproperty
   a_idle_mux: assert property (p_idle_mux) else $error("channel held while idle");
   property p_seq_pick;
      @(posedge mclk) disable iff (reset)
      (st_reg == sar_ctrl_pkg::ST_ACQ && cs_rise && !nap && !power_down && seq_enable)
      |=> ch_reg == $past(seq_mem[seq_ptr_reg][5:3])
          && sp_reg == $past(seq_mem[seq_ptr_reg][2:0]);
   endproperty
   a_seq_pick: assert property (p_seq_pick) else $error("list entry not applied");
   c_conv: cover property (@(posedge mclk) out_valid);
   c_seq: cover property (@(posedge mclk) out_valid && seq_enable);
   c_bip: cover property (@(posedge mclk) out_valid && bipolar);
   c_nap: cover property (@(posedge mclk) nap || power_down);
endmodule
`default_nettype wire

// File: sar_ctrl_params.svh
// Function
// - Convert start rising edge holds and converts
// - Eighteen step binary search, half downward
// - Finished code placed into parallel output register
// - Span quantised into two-to-eighteen codes
// - Channel and span chosen per conversion
// - Sequencer steps stored channel/span list
// - Eight channels, one selected per conversion
// - Mux change applies with no settling delay
// - Spans 7,6,3,2 are bipolar
// - Spans 5,4,1,0 are unipolar
// - Bipolar results in two's complement
// - Unipolar results in straight binary
// - Select pin chooses CMOS or LVDS port
// - Nap and power-down during idle periods
`ifndef SAR_CTRL_PARAMS_SVH
`define SAR_CTRL_PARAMS_SVH
`define RES_BITS     18
`define NUM_CH       8
`define SEQ_DEPTH    8
`define SPAN_BIPOLAR_MASK 8'hcc
`endif

// File: sar_ctrl_pkg.sv
package sar_ctrl_pkg;
   typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_DONE} conv_state_t;
   typedef enum logic [1:0] {PM_ACTIVE, PM_NAP, PM_DOWN} power_t;
endpackage

// File: sar_search.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctrl_params.svh"
module sar_search #(
   parameter int W = `RES_BITS
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         start,
   input  wire logic         comp_in,
   output logic [W-1:0]      dac_code,
   output logic [W-1:0]      result,
   output logic              done
);
   logic [W-1:0] trial_reg, trial_next, code_reg, code_next;
   logic         done_reg, done_next;
   if (W < 2) begin : g_bad_width
      $error("search width too small");
   end
   always_comb begin
      trial_next = trial_reg;
      code_next  = code_reg;
      done_next  = 1'b0;
      if (start) begin
         trial_next = {1'b1, {(W-1){1'b0}}};
         code_next  = {1'b1, {(W-1){1'b0}}};
      end else if (trial_reg != '0) begin
         // Comparator says input below trial: drop this bit
         if (!comp_in) code_next = code_reg & ~trial_reg;
         trial_next = trial_reg >> 1;
         if (trial_reg[0]) done_next = 1'b1;
         else code_next = (comp_in ? code_reg : code_reg & ~trial_reg) | (trial_reg >> 1);
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         trial_reg <= '0;
         code_reg  <= '0;
         done_reg  <= 1'b0;
      end else begin
         trial_reg <= trial_next;
         code_reg  <= code_next;
         done_reg  <= done_next;
      end
   end
   assign dac_code = code_reg;
   assign result   = code_reg;
   assign done     = done_reg;
   // Start loads the half-scale trial, then one edge per bit, then done
   property p_eighteen;
      @(posedge mclk) disable iff (reset) start |-> ##19 done;
   endproperty
   a_eighteen: assert property (p_eighteen) else $error("search length wrong");
   property p_onehot;
      @(posedge mclk) disable iff (reset) $onehot0(trial_reg);
   endproperty
   a_onehot: assert property (p_onehot) else $error("trial not one-hot");
endmodule
`default_nettype wire

// File: sar_comparator_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************
// Comparator stand-in for the held input
// ************************************************
module sar_comparator_model (
   input  wire logic [17:0] dac_code,
   input  wire logic [17:0] target,
   output logic             comp_in
);
   // Ideal and offset-free; held input fixed for whole search
   assign comp_in = (target >= dac_code);
endmodule
`default_nettype wire

// File: sar_adc_conversion_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_control_bench;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        convert_start = 1'b0;
   logic        comp_in;
   logic [2:0]  chan_sel = 3'h0;
   logic [2:0]  span_sel = 3'h0;
   logic        seq_enable = 1'b0;
   logic        seq_write = 1'b0;
   logic [2:0]  seq_addr = 3'h0;
   logic [5:0]  seq_data = 6'h00;
   logic [2:0]  seq_len_m1 = 3'h0;
   logic        lvds_select = 1'b0;
   logic        nap_req = 1'b0;
   logic        pd_req = 1'b0;
   logic        busy, hold, out_valid, cmos_en, lvds_en, nap, power_down;
   logic [7:0]  mux_en;
   logic [17:0] dac_code, out_data;
   logic [2:0]  out_chan, out_span;
   logic [17:0] target = 18'h00000;
   logic [2:0]  xmask = 3'h0;
   logic [17:0] tv [8] = '{18'h00000, 18'h3ffff, 18'h20000, 18'h1ffff,
                           18'h2a5a5, 18'h15a5a, 18'h00001, 18'h3fffe};
   int          n_fail = 0;
   int          comparisons = 0;
   int          cycles = 0;

   // ************************************************
   // Clock, timeout and hookup
   // ************************************************
   always #50 mclk = ~mclk;

   // Whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up();
      end
   end

   sar_adc_conversion_control uut (.mclk(mclk), .reset(reset),
      .convert_start(convert_start), .comp_in(comp_in), .chan_sel(chan_sel),
      .span_sel(span_sel), .seq_enable(seq_enable), .seq_write(seq_write),
      .seq_addr(seq_addr), .seq_data(seq_data), .seq_len_m1(seq_len_m1),
      .lvds_select(lvds_select), .nap_req(nap_req), .pd_req(pd_req),
      .busy(busy), .hold(hold), .mux_en(mux_en), .dac_code(dac_code),
      .out_data(out_data), .out_chan(out_chan), .out_span(out_span),
      .out_valid(out_valid), .cmos_en(cmos_en), .lvds_en(lvds_en),
      .nap(nap), .power_down(power_down));

   sar_comparator_model cmp (.dac_code(dac_code), .target(target), .comp_in(comp_in));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic step;
      @(posedge mclk);
      #10;
   endtask

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic do_reset;
      reset = 1'b1;
      repeat (5) step();
      reset = 1'b0;
   endtask

   // One conversion; xmask garbles the pins when the list should win
   task automatic conv(input logic [2:0] ch, input logic [2:0] sp, input logic [17:0] tgt);
      logic [17:0] exp_d;
      int          n;
      exp_d = (sp inside {3'h7, 3'h6, 3'h3, 3'h2}) ? (tgt ^ 18'h20000) : tgt;
      target = tgt;
      chan_sel = ch ^ xmask;
      span_sel = sp ^ xmask;
      convert_start = 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
         step();
         n++;
      end
      check(hold, 1'b1);
      check(mux_en, 8'h01 << ch);
      check(dac_code, 18'h20000);
      convert_start = 1'b0;
      n = 0;
      while (out_valid !== 1'b1 && n < 40) begin
         step();
         n++;
      end
      check(18'(n), 18'h00014);
      check(busy, 1'b0);
      check(out_data, exp_d);
      check(dac_code, tgt);
      check(out_chan, ch);
      check(out_span, sp);
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic test_spans;
      for (int i = 0; i < 8; i++) begin
         conv(3'(7 - i), 3'(i), tv[i]);
      end
      $display("spans done");
   endtask

   task automatic test_refuse;
      int pulses;
      pulses = 0;
      convert_start = 1'b1;
      repeat (6) step();
      convert_start = 1'b0;
      repeat (3) step();
      convert_start = 1'b1;
      repeat (3) step();
      convert_start = 1'b0;
      repeat (60) begin
         step();
         if (out_valid === 1'b1) pulses++;
      end
      check(18'(pulses), 18'h00001);
      $display("refuse done");
   endtask

   task automatic test_port;
      for (int k = 0; k < 2; k++) begin
         lvds_select = k[0];
         repeat (4) step();
         check(lvds_en, k[0]);
         check(cmos_en, !k[0]);
      end
      lvds_select = 1'b0;
      $display("port done");
   endtask

   task automatic test_power;
      int seen;
      for (int k = 0; k < 2; k++) begin
         seen = 0;
         nap_req = (k == 0);
         pd_req = (k == 1);
         repeat (4) step();
         check({nap, power_down}, (k == 0) ? 18'h2 : 18'h1);
         convert_start = 1'b1;
         repeat (30) begin
            step();
            if (busy === 1'b1 || out_valid === 1'b1) seen++;
         end
         convert_start = 1'b0;
         check(18'(seen), 18'h0);
         nap_req = 1'b0;
         pd_req = 1'b0;
         repeat (4) step();
         check({nap, power_down}, 18'h0);
      end
      $display("power done");
   endtask

   task automatic test_seq;
      logic [5:0] ent [3] = '{6'h3b, 6'h04, 6'h2e};
      for (int i = 0; i < 3; i++) begin
         seq_write = 1'b1;
         seq_addr = 3'(i);
         seq_data = ent[i];
         step();
      end
      seq_write = 1'b0;
      seq_len_m1 = 3'h2;
      seq_enable = 1'b1;
      xmask = 3'h5;
      // Fourth pass shows the pointer wrapping
      for (int i = 0; i < 4; i++) begin
         conv(ent[i % 3][5:3], ent[i % 3][2:0], 18'h12345 + 18'(i));
      end
      seq_enable = 1'b0;
      xmask = 3'h0;
      $display("sequencer done");
   endtask

   initial begin
      do_reset();
      check(cmos_en, 1'b1);
      test_spans();
      test_refuse();
      test_port();
      test_power();
      do_reset();
      test_seq();
      wrap_up();
   end
endmodule
`default_nettype wire
